//--- include/supervisor_pkg.sv
/*
 * constants for the wakeup / watchdog / reset supervisor.
 * assumes a 125 MHz device clock; times are held in their own unit and
 * converted to cycle counts here.
 */
package supervisor_pkg;
    localparam int unsigned clk_mhz = 125;
    // response limits in ns
    localparam int unsigned wake_resp_max_ns = 5000;
    localparam int unsigned wake_resp_max_cyc = (wake_resp_max_ns * clk_mhz) / 1000;
    // default timebase in us (longer timing option at reference setting)
    localparam int unsigned wake_period_us = 75000;
    localparam int unsigned reset_pulse_us = 9000;
    localparam int unsigned reset_to_wake_us = 37500;
    localparam int unsigned wake_period_cyc = wake_period_us * clk_mhz;
    localparam int unsigned reset_pulse_cyc = reset_pulse_us * clk_mhz;
    localparam int unsigned reset_to_wake_cyc = reset_to_wake_us * clk_mhz;
    localparam int cnt_w = 32;
endpackage : supervisor_pkg

//--- rtl/sync_edge.sv
/*
 * two-flop synchroniser with falling-edge detector.
 * assumes an asynchronous input and a reset synchronised to clk.
 */
`timescale 1ns/1ps
module sync_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // async input
    input wire logic din,
    // synchronised level and falling-edge pulse
    output logic level,
    output logic fall
);
    logic meta;
    logic stable;
    logic prev;
    logic next_fall;

    always_comb begin
        next_fall = prev & ~stable;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b1;
            stable <= 1'b1;
            prev <= 1'b1;
            fall <= 1'b0;
        end else begin
            meta <= din;
            stable <= meta;
            prev <= stable;
            fall <= next_fall;
        end
    end

    assign level = stable;
endmodule : sync_edge

//--- rtl/wakeup_watchdog_reset_supervisor.sv
/*
 * wakeup square wave generator, watchdog and active-low reset supervisor.
 * assumes the host drives service_pulse_in and supply_ok comes from an
 * analog comparator; both are asynchronous and are synchronised here.
 */
// Function
// (RULE1) only falling service edges count as service
// (RULE2) service edge drives wakeup low
// (RULE3) wakeup falls within 5 us of edge
// (RULE4) wakeup falls within 5 us of reset
// (RULE5) wait after reset before wakeup rises
// (RULE6) hold reset until supply in regulation
// (RULE7) reset while supply out of regulation
// (RULE8) reset pulse when period lacks service
// (RULE9) host answers wakeup with service pulse
// (RULE10) extra edges in same cycle ignored
// (RULE11) wakeup low during reset, then restarts
// (RULE12) wakeup is 50 percent square wave
// (RULE13) timeout reset at cycle end only
// (RULE14) timebase as cycle parameters, synchronised supply flag
// (RULE15) service input synchronised before edge detection
`timescale 1ns/1ps
module wakeup_watchdog_reset_supervisor #(
    parameter int unsigned period_cyc = supervisor_pkg::wake_period_cyc,
    parameter int unsigned pulse_cyc = supervisor_pkg::reset_pulse_cyc,
    parameter int unsigned delay_cyc = supervisor_pkg::reset_to_wake_cyc
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // supply monitor and host service input
    input wire logic supply_ok,
    input wire logic service_pulse_in,
    // outputs to host
    output logic wakeup,
    output logic host_reset_n
);
    typedef enum logic [3:0] {
        st_reset = 4'b0001,
        st_delay = 4'b0010,
        st_high = 4'b0100,
        st_low = 4'b1000
    } state_e;

    localparam logic [31:0] half_cyc = 32'(period_cyc / 2);
    localparam logic [31:0] pulse_c = 32'(pulse_cyc);
    localparam logic [31:0] delay_c = 32'(delay_cyc);

    localparam int resp_max = int'(supervisor_pkg::wake_resp_max_cyc);

    logic rs0, rs1;
    logic sup_meta, sup_ok;
    logic svc_fall;
    logic svc_level;
    state_e state, next_state;
    logic [supervisor_pkg::cnt_w-1:0] cnt, next_cnt;
    logic serviced, next_serviced;
    logic next_wakeup, next_host_reset_n;

    // true in the last cycle of a span of limit cycles
    function automatic logic count_done(input logic [31:0] count, input logic [31:0] limit);
        count_done = (count >= limit - 32'h1);
    endfunction : count_done

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rs0 <= 1'b0;
            rs1 <= 1'b0;
        end else begin
            rs0 <= 1'b1;
            rs1 <= rs0;
        end
    end

    always_ff @(posedge clk or negedge rs1) begin
        if (!rs1) begin
            sup_meta <= 1'b0;
            sup_ok <= 1'b0;
        end else begin
            sup_meta <= supply_ok; // RULE14
            sup_ok <= sup_meta;
        end
    end

    sync_edge u_svc (
        .clk(clk),
        .rst_n(rs1),
        .din(service_pulse_in), // RULE15
        .level(svc_level),
        .fall(svc_fall) // RULE1
    );

    always_comb begin
        next_state = state;
        next_cnt = cnt + 32'h1;
        next_serviced = serviced;
        unique case (state)
            st_reset: begin
                // held until supply good and pulse time served
                if (!sup_ok) begin
                    next_cnt = 32'h0; // RULE6 RULE7
                end else if (count_done(cnt, pulse_c)) begin
                    next_state = st_delay;
                    next_cnt = 32'h0;
                end
            end
            st_delay: begin
                if (count_done(cnt, delay_c)) begin
                    next_state = st_high; // RULE5
                    next_cnt = 32'h0;
                    next_serviced = 1'b0;
                end
            end
            st_high: begin
                if (svc_fall && !serviced) begin
                    next_serviced = 1'b1; // RULE2 RULE10
                end
                if (count_done(cnt, half_cyc)) begin
                    next_state = st_low; // RULE12
                    next_cnt = 32'h0;
                end
            end
            st_low: begin
                if (svc_fall) begin
                    next_serviced = 1'b1;
                end
                if (count_done(cnt, half_cyc)) begin
                    next_cnt = 32'h0;
                    next_serviced = 1'b0;
                    if (serviced || svc_fall) begin
                        next_state = st_high;
                    end else begin
                        next_state = st_reset; // RULE8 RULE13
                    end
                end
            end
        endcase
        if (!sup_ok && state != st_reset) begin
            next_state = st_reset; // RULE7
            next_cnt = 32'h0;
        end
        next_host_reset_n = (next_state != st_reset);
        // low whenever not in high half or already serviced
        next_wakeup = (next_state == st_high) && !next_serviced; // RULE3 RULE4 RULE11
    end

    always_ff @(posedge clk or negedge rs1) begin
        if (!rs1) begin
            state <= st_reset;
            cnt <= 32'h0;
            serviced <= 1'b0;
            wakeup <= 1'b0;
            host_reset_n <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            serviced <= next_serviced;
            wakeup <= next_wakeup;
            host_reset_n <= next_host_reset_n;
        end
    end

    // checks on the outputs and the service path

    chk_wake_fall_svc: assert property (@(posedge clk) disable iff (!rs1) // RULE2
        (svc_fall && wakeup) |-> ##1 !wakeup)
        else $error("wakeup not low after service");

    chk_wake_resp: assert property (@(posedge clk) disable iff (!rs1) // RULE3
        $fell(svc_level) && wakeup |-> ##[1:3] !wakeup)
        else $error("wakeup slow");

    chk_wake_in_reset: assert property (@(posedge clk) disable iff (!rs1) // RULE11
        !host_reset_n |-> !wakeup)
        else $error("wakeup high in reset");

    chk_reset_supply: assert property (@(posedge clk) disable iff (!rs1) // RULE7
        !sup_ok |-> ##[1:2] !host_reset_n)
        else $error("no reset on low supply");

    chk_reset_wake: assert property (@(posedge clk) disable iff (!rs1) // RULE4
        $fell(host_reset_n) |-> !wakeup)
        else $error("wakeup high at reset");

    chk_reset_resp: assert property (@(posedge clk) disable iff (!rs1) // RULE4
        $fell(sup_ok) |-> ##[1:resp_max] !wakeup)
        else $error("wakeup slow after supply loss");

    chk_delay_low: assert property (@(posedge clk) disable iff (!rs1) // RULE5
        $rose(host_reset_n) |-> !wakeup [*2])
        else $error("wakeup rose without delay");

    chk_delay_len: assert property (@(posedge clk) disable iff (!rs1) // RULE5
        (state == st_delay && !count_done(cnt, delay_c)) |=> !wakeup)
        else $error("wakeup rose before delay end");

    chk_wake_restart: assert property (@(posedge clk) disable iff (!rs1) // RULE11
        (state == st_delay && count_done(cnt, delay_c) && sup_ok) |=> wakeup)
        else $error("wakeup did not restart");

    chk_release_supply: assert property (@(posedge clk) disable iff (!rs1) // RULE6
        $rose(host_reset_n) |-> $past(sup_ok))
        else $error("reset released without supply");

    chk_pulse_len: assert property (@(posedge clk) disable iff (!rs1) // RULE8
        (state == st_reset && sup_ok && !count_done(cnt, pulse_c)) |=> !host_reset_n)
        else $error("reset pulse too short");

    chk_timeout_end: assert property (@(posedge clk) disable iff (!rs1) // RULE8
        ($fell(host_reset_n) && $past(sup_ok))
        |-> ($past(state) == st_low && !$past(serviced) && !$past(svc_fall)))
        else $error("bad timeout");

    chk_timeout_edge: assert property (@(posedge clk) disable iff (!rs1) // RULE13
        ($fell(host_reset_n) && sup_ok && $past(sup_ok)) |-> $past(cnt) == half_cyc - 32'h1)
        else $error("timeout mid-cycle");

    chk_low_len: assert property (@(posedge clk) disable iff (!rs1) // RULE13
        (state == st_low && sup_ok && !count_done(cnt, half_cyc)) |=> state == st_low)
        else $error("low half cut short");

    chk_high_len: assert property (@(posedge clk) disable iff (!rs1) // RULE12
        (state == st_high && sup_ok && !count_done(cnt, half_cyc)) |=> state == st_high)
        else $error("high half cut short");

    chk_once_cycle: assert property (@(posedge clk) disable iff (!rs1) // RULE10
        (state == st_high && serviced && svc_fall) |=> (serviced && !wakeup))
        else $error("second edge acted");

    chk_fall_only: assert property (@(posedge clk) disable iff (!rs1) // RULE1
        svc_fall |-> ($past(svc_level, 2) && !$past(svc_level)))
        else $error("service event without falling edge");

    chk_svc_once: assert property (@(posedge clk) disable iff (!rs1) // RULE15
        svc_fall |=> !svc_fall)
        else $error("service edge counted twice");
endmodule : wakeup_watchdog_reset_supervisor

//--- test/host_model.sv
/*
 * host processor model: answers each wakeup rise with two service falls while enable is high.
 * assumes wakeup and clk come from the supervisor bench.
 */
`timescale 1ns/1ps
module host_model (
    // clock and control
    input wire logic clk,
    input wire logic enable,
    // supervisor side
    input wire logic wakeup,
    output logic service_pulse_in
);
    // second fall lands in the same cycle and must be ignored
    initial begin
        service_pulse_in = 1'b1;
        forever begin
            @(posedge wakeup);
            if (enable) begin
                repeat (2) begin
                    repeat (3) @(posedge clk);
                    #1 service_pulse_in = 1'b0;
                    repeat (4) @(posedge clk);
                    #1 service_pulse_in = 1'b1;
                end
            end
        end
    end
endmodule : host_model

//--- test/tb.sv
/*
 * self-checking bench for the supervisor with shortened timebase.
 * assumes host_model answers wakeup while host_en is high.
 */
`timescale 1ns/1ps
module tb;
    localparam int per = 200;
    localparam int pul = 20;
    localparam int dly = 40;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic supply_ok = 1'b0;
    logic host_en = 1'b1;
    logic service_pulse_in;
    logic wakeup;
    logic host_reset_n;
    int miscompares = 0;
    int checks = 0;
    int n;
    int m;
    always #4 clk = ~clk;
    wakeup_watchdog_reset_supervisor #(.period_cyc(per), .pulse_cyc(pul), .delay_cyc(dly)) dut (
        .clk(clk), .reset_n(reset_n), .supply_ok(supply_ok),
        .service_pulse_in(service_pulse_in), .wakeup(wakeup), .host_reset_n(host_reset_n));
    host_model host (.clk(clk), .enable(host_en), .wakeup(wakeup),
        .service_pulse_in(service_pulse_in));
    task check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    // cycles until the chosen output reaches v
    task wait_sig(input bit on_rst, input logic v, output int cnt);
        cnt = 0;
        while (((on_rst ? host_reset_n : wakeup) !== v) && cnt < 1000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 1000) begin
            miscompares++;
            $display("unexpected at %0t: wait limit reached", $time);
        end
    endtask : wait_sig
    task power_up;
        repeat (30) @(posedge clk);
        #1;
        check(host_reset_n === 1'b0 && wakeup === 1'b0, "reset low before supply");
        supply_ok = 1'b1;
        wait_sig(1, 1'b1, n);
        check(n inside {[pul:pul+6]}, "reset release time");
        wait_sig(0, 1'b1, n);
        check(n inside {[dly-1:dly+2]}, "reset to wakeup delay");
    endtask : power_up
    task service;
        repeat (3) begin
            wait_sig(0, 1'b0, n);
            check(n <= 12, "wakeup response to service");
            wait_sig(0, 1'b1, m);
            check((n + m) inside {[per-1:per+1]}, "serviced period");
            check(host_reset_n === 1'b1, "no reset when serviced");
        end
    endtask : service
    task timeout;
        host_en = 1'b0;
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, n);
        wait_sig(0, 1'b0, n);
        check(n inside {[per/2-1:per/2+1]}, "high half");
        wait_sig(1, 1'b0, m);
        check((n + m) inside {[per-2:per+4]}, "timeout at cycle end");
        check(wakeup === 1'b0, "wakeup low in reset");
        host_en = 1'b1;
        wait_sig(1, 1'b1, n);
        check(n inside {[pul-1:pul+2]}, "timeout pulse width");
        wait_sig(0, 1'b1, n);
        check(n inside {[dly-1:dly+2]}, "wakeup restarts");
    endtask : timeout
    task supply_drop;
        supply_ok = 1'b0;
        wait_sig(1, 1'b0, n);
        check(n <= 4, "reset on supply loss");
        wait_sig(0, 1'b0, m);
        check(m <= 2, "wakeup follows reset");
        repeat (50) @(posedge clk);
        #1;
        check(host_reset_n === 1'b0, "reset held");
        supply_ok = 1'b1;
        wait_sig(1, 1'b1, n);
        check(n inside {[pul:pul+6]}, "reset after recovery");
    endtask : supply_drop
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(posedge clk);
        #1 reset_n = 1'b1;
        power_up();
        service();
        timeout();
        supply_drop();
        end_sim();
    end
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end
endmodule : tb
